/* acc_checker.sv */
// Purpose: port checks
// Assumes: ctrl at 0x00
// Notes: shadows ctrl fields
`timescale 1ns/1ps
module acc_checker (
  input wire logic                      clk,
  input wire logic                      rst_n,
  input wire acc_pkg::acc_bus_req_type  bus_req,
  input wire logic [31:0]               bus_rdata,
  input wire logic                      core_out_async,
  input wire acc_pkg::acc_core_cfg_type core_cfg,
  input wire logic                      comparator_output_pin,
  input wire logic                      comparator_output_pin_oe_n,
  input wire logic                      irq
);
  import acc_pkg::*;
  logic [15:0] c_q;
  logic [1:0]  ev;
  logic        wc;
  assign wc = bus_req.wr && bus_req.addr == 8'h00;
  assign ev = c_q[7:6];
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n) c_q <= 16'h00c3;
    else if (wc) c_q <= bus_req.wdata[15:0] & 16'he0d3;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence st;
    (core_cfg.enable && $stable(core_out_async) && $stable(c_q))[*4];
  endsequence
  chk_cfg_follow: assert property (
    wc |=> core_cfg == {c_q[15], c_q[4], c_q[1:0]}) else $error("cfg");
  chk_oe_level: assert property (
    $stable(c_q)[*3] |-> comparator_output_pin_oe_n == !c_q[14]) else $error("oe");
  chk_pin_off: assert property (
    comparator_output_pin_oe_n |-> !comparator_output_pin) else $error("pin off");
  chk_pin_value: assert property (
    st ##0 !comparator_output_pin_oe_n |-> comparator_output_pin == (core_out_async ^ c_q[13]))
    else $error("pin");
  chk_result_bit: assert property (
    st ##0 (bus_req.rd && bus_req.addr == 8'h00) |=> bus_rdata[8] == $past(core_out_async))
    else $error("result");
  chk_reserved_zero: assert property (
    bus_req.rd |=> (bus_rdata & 32'hffff_1e2c) == 32'h0) else $error("reserved");
  chk_irq_mask: assert property (
    bus_req.wr && bus_req.addr == 8'h18 && !bus_req.wdata[0] |=> !irq) else $error("mask");
  chk_edge_none: assert property (
    $rose(irq) |-> $past(bus_req.wr) || $past(ev) != 2'h0) else $error("edge none");
endmodule
bind acc_comparator_control acc_checker i_acc_checker (.clk(clk), .rst_n(rst_n),
  .bus_req(bus_req), .bus_rdata(bus_rdata), .core_out_async(core_out_async),
  .core_cfg(core_cfg), .comparator_output_pin(comparator_output_pin),
  .comparator_output_pin_oe_n(comparator_output_pin_oe_n), .irq(irq));

/* acc_comparator_control.sv */
// Purpose: control register, input routing, output pin and interrupt of one comparator
// Assumes: analog core output is asynchronous; bus is synchronous to clk
// Notes:   read data valid the cycle after the read strobe
//
// Design decisions made here: the address map and the strobed register port.
`timescale 1ns/1ps
`include "acc_regs.svh"

module acc_comparator_control (
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire acc_pkg::acc_bus_req_type bus_req,
  output logic [31:0]                   bus_rdata,
  input  wire logic                     core_out_async,
  output acc_pkg::acc_core_cfg_type     core_cfg,
  output logic                          comparator_output_pin,
  output logic                          comparator_output_pin_oe_n,
  output logic                          irq
);
  import acc_pkg::*;

  // ****************************************
  // control register
  // ****************************************
  logic [31:0] ctrl_q;
  logic        sync1_q;
  logic        sync2_q;
  logic        prev_q;
  logic        pin_q;
  logic        pin_oe_n_q;
  logic [0:0]  stat_q;
  logic [0:0]  en_q;
  logic [31:0] rdata_q;
  logic        wr_ctrl;
  logic        wr_clr;
  logic        wr_en;
  logic        presented;
  logic        edge_hit;
  acc_edge_type edge_sel;

  assign wr_ctrl = bus_req.wr && (bus_req.addr == `ACC_OFF_CTRL);
  assign wr_clr  = bus_req.wr && (bus_req.addr == `ACC_OFF_INT_CLR);
  assign wr_en   = bus_req.wr && (bus_req.addr == `ACC_OFF_INT_EN);

  // masked write keeps reserved bits zero and loads the writable fields from wdata
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= `ACC_CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_q <= bus_req.wdata & `ACC_CTRL_WMASK;
    end
  end

  // ****************************************
  // core configuration
  // ****************************************
  // config fields stay stored while disabled
  assign core_cfg.enable  = ctrl_q[`ACC_BIT_ON];
  assign core_cfg.pos_sel = ctrl_q[`ACC_BIT_PSEL];
  assign core_cfg.neg_sel = ctrl_q[`ACC_BIT_NSEL_HI:`ACC_BIT_NSEL_LO];

  // ****************************************
  // result synchroniser
  // ****************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end else begin
      sync1_q <= core_out_async;
      sync2_q <= sync1_q & ctrl_q[`ACC_BIT_ON];
    end
  end

  assign presented = sync2_q ^ ctrl_q[`ACC_BIT_INV];

  // ****************************************
  // output pin
  // ****************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_q      <= 1'b0;
      pin_oe_n_q <= 1'b1;
    end else begin
      pin_q      <= presented & ctrl_q[`ACC_BIT_OE];
      pin_oe_n_q <= ~ctrl_q[`ACC_BIT_OE];
    end
  end

  assign comparator_output_pin      = pin_q;
  assign comparator_output_pin_oe_n = pin_oe_n_q;

  // ****************************************
  // edge detection and interrupt
  // ****************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= presented;
    end
  end

  assign edge_sel = acc_edge_type'(ctrl_q[`ACC_BIT_EDGE_HI:`ACC_BIT_EDGE_LO]);

  always_comb begin
    case (edge_sel)
      ACC_EDGE_RISE: edge_hit = presented & ~prev_q;
      ACC_EDGE_FALL: edge_hit = ~presented & prev_q;
      ACC_EDGE_BOTH: edge_hit = presented ^ prev_q;
      default:       edge_hit = 1'b0;
    endcase
  end

  // set wins over a same-cycle clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stat_q <= 1'b0;
    end else begin
      stat_q <= (stat_q & ~(wr_clr ? bus_req.wdata[0:0] : 1'b0))
                | (edge_hit & ctrl_q[`ACC_BIT_ON]);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      en_q <= 1'b0;
    end else if (wr_en) begin
      en_q <= bus_req.wdata[0:0];
    end
  end

  assign irq = |(stat_q & en_q);

  // ****************************************
  // read path
  // ****************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 32'h0000_0000;
    end else if (bus_req.rd) begin
      case (bus_req.addr)
        `ACC_OFF_CTRL: begin
          rdata_q <= ctrl_q | {23'h000000, sync2_q, 8'h00};
        end
        `ACC_OFF_INT_STAT: rdata_q <= {31'h00000000, stat_q};
        `ACC_OFF_INT_EN:   rdata_q <= {31'h00000000, en_q};
        default:           rdata_q <= 32'h0000_0000;
      endcase
    end else begin
      rdata_q <= 32'h0000_0000;
    end
  end

  assign bus_rdata = rdata_q;

endmodule

/* acc_core_model.sv */
// Purpose: analog comparator core model
// Assumes: lv holds six 4-bit levels
// Notes: output settles off the edge
`timescale 1ns/1ps
module acc_core_model (
  input wire acc_pkg::acc_core_cfg_type cfg,
  input wire logic [23:0]               lv,
  output logic                          out
);
  import acc_pkg::*;
  logic [3:0] p;
  logic [3:0] n;
  assign p = lv[4 * cfg.pos_sel +: 4];
  assign n = lv[8 + 4 * cfg.neg_sel +: 4];
  assign #1 out = cfg.enable && (p > n);
endmodule

/* acc_pkg.sv */
// Purpose: types for the analog comparator channel control block
// Assumes: acc_regs.svh supplies numeric constants
// Notes:   none
package acc_pkg;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } acc_bus_req_type;

  typedef struct packed {
    logic       enable;
    logic       pos_sel;
    logic [1:0] neg_sel;
  } acc_core_cfg_type;

  typedef enum logic [1:0] {
    ACC_EDGE_NONE = 2'h0,
    ACC_EDGE_RISE = 2'h1,
    ACC_EDGE_FALL = 2'h2,
    ACC_EDGE_BOTH = 2'h3
  } acc_edge_type;

endpackage

/* acc_regs.svh */
// Purpose: constants for the analog comparator channel control block
// Assumes: 32-bit plain register port, word addressed by byte offset
// Notes:   offsets of the control and interrupt registers are local choices
//
// Contract
// - enable bit 15 switches comparator; toggling leaves other fields intact
// - bit 14 set drives result onto output pin, clear does not
// - bit 13 set inverts the presented result
// - inversion also feeds edge detection, so interrupt edge flips
// - bit 8 reads back current comparator output level
// - bits 7-6 pick edge: 11 both, 10 fall, 01 rise, 00 none
// - bit 4 set picks internal reference, clear picks external positive pin
// - bits 1-0 pick inverting input among four sources per channel
// - bits 31-16, 12-9, 5, 3-2 read zero and ignore writes
// - disabled comparator idles without current, configuration kept
`ifndef ACC_REGS_SVH
`define ACC_REGS_SVH

// ****************************************
// register offsets
// ****************************************
`define ACC_OFF_CTRL      8'h00
`define ACC_OFF_INT_STAT  8'h10
`define ACC_OFF_INT_CLR   8'h14
`define ACC_OFF_INT_EN    8'h18

// ****************************************
// field positions and reset
// ****************************************
`define ACC_BIT_ON        15
`define ACC_BIT_OE        14
`define ACC_BIT_INV       13
`define ACC_BIT_RES       8
`define ACC_BIT_EDGE_HI   7
`define ACC_BIT_EDGE_LO   6
`define ACC_BIT_PSEL      4
`define ACC_BIT_NSEL_HI   1
`define ACC_BIT_NSEL_LO   0
`define ACC_CTRL_WMASK    32'h0000_e0d3
`define ACC_CTRL_RESET    32'h0000_00c3
`define ACC_INT_BITS      1

`endif

/* tb_top.sv */
// Purpose: self-checking bench
// Assumes: core model as far side
// Notes: reads checked after strobe
`timescale 1ns/1ps
module tb_top;
  import acc_pkg::*;
  logic clk = 0, rst_n = 0, out, pin, oe_n, irq, rd_d = 0;
  acc_bus_req_type  bus_req = '0;
  acc_core_cfg_type core_cfg;
  logic [31:0] bus_rdata, q[$];
  logic [23:0] lv = 24'h000800;
  int failures = 0, comparisons = 0, cyc = 0;
  always #2.5 clk = ~clk;
  acc_core_model i_acc_core_model (.cfg(core_cfg), .lv(lv), .out(out));
  acc_comparator_control i_acc_comparator_control (.clk(clk), .rst_n(rst_n),
    .bus_req(bus_req), .bus_rdata(bus_rdata), .core_out_async(out), .core_cfg(core_cfg),
    .comparator_output_pin(pin), .comparator_output_pin_oe_n(oe_n), .irq(irq));
  task automatic chk(string s, logic [31:0] e, logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic acc(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    bus_req <= '{a, d, w, !w};
    if (!w) q.push_back(d);
    @(posedge clk);
    bus_req <= '0;
  endtask
  always @(posedge clk) begin
    rd_d <= bus_req.rd;
    cyc <= cyc + 1;
    if (rd_d) chk("rdata", q.pop_front(), bus_rdata);
    if (cyc > 5000) begin
      failures++;
      report_and_stop();
    end
  end
  initial begin
    logic [31:0] d;
    logic [1:0] e;
    logic v;
    void'($urandom(39971));
    repeat (10) @(posedge clk);
    rst_n <= 1;
    acc(0, 8'h00, 32'hc3);
    acc(0, 8'h20, 0);
    acc(1, 8'h00, '1);
    acc(0, 8'h00, 32'he0d3);
    acc(1, 8'h00, 32'h60d3);
    acc(0, 8'h00, 32'h60d3);
    acc(1, 8'h18, 1);
    for (int i = 0; i < 8; i++) begin
      e = i[1:0];
      v = i[2];
      d = 32'hc000 | (v << 13) | (e << 6);
      acc(1, 8'h00, d);
      repeat (6) @(posedge clk);
      acc(1, 8'h14, 1);
      lv[3:0] <= 4'hf;
      repeat (6) @(posedge clk);
      chk("pin", !v, pin);
      chk("oe_n", 0, oe_n);
      chk("irq", v ? e[1] : e[0], irq);
      acc(0, 8'h00, d | 32'h100);
      lv[3:0] <= 4'h0;
      repeat (6) @(posedge clk);
      acc(0, 8'h10, e != 0);
    end
    acc(1, 8'h18, 0);
    @(posedge clk);
    chk("irq", 0, irq);
    for (int i = 0; i < 8; i++) begin
      lv <= 24'($urandom);
      d = ($urandom & 32'h13) | 32'h8000;
      acc(1, 8'h00, d);
      repeat (6) @(posedge clk);
      chk("cfg", {d[15], d[4], d[1:0]}, core_cfg);
      chk("oe_n", 1, oe_n);
      chk("pin", 0, pin);
      acc(0, 8'h00, d | ((lv[4 * d[4] +: 4] > lv[8 + 4 * d[1:0] +: 4]) << 8));
    end
    repeat (3) @(posedge clk);
    report_and_stop();
  end
endmodule
